// >>> hdl/aebm_lane.sv
`timescale 1ns/1ns
module aebm_lane (
  // operand state
  input  wire logic [31:0] op,
  input  wire logic [2:0]  rem,
  input  wire logic        addr0,
  input  wire logic        port16,
  // data pins
  input  wire logic [15:0] rd_bus,
  // lane results
  output logic             wide,
  output logic [15:0]      wr_lanes,
  output logic [15:0]      rd_bits
);

  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] rd_byte;

  assign b0 = op[31:24];
  assign b1 = op[23:16];

  // only an aligned 16-bit port takes two bytes at once
  assign wide = port16 && !addr0 && (rem >= aebm_pkg::REM_TWO);

  always_comb
  begin
    // all sixteen lines driven; single byte copied to both lanes
    if (addr0 || rem == aebm_pkg::REM_ONE)
      wr_lanes = {b0, b0};
    else
      wr_lanes = {b0, b1};
  end

  always_comb
  begin
    // 8-bit port sits on the upper lane
    if (port16 && addr0)
      rd_byte = rd_bus[7:0];
    else
      rd_byte = rd_bus[15:8];
    if (wide)
      rd_bits = rd_bus;
    else
      rd_bits = {8'h00, rd_byte};
  end

endmodule : aebm_lane

// >>> hdl/aebm_master.sv
`timescale 1ns/1ns
module aebm_master #(
  parameter int MON_CYCLES = aebm_pkg::MON_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  // transfer request
  input  wire logic                         req_valid,
  input  wire aebm_pkg::aebm_req_t          req,
  output logic                              req_ready,
  // transfer result
  output logic                              rsp_valid,
  output aebm_pkg::aebm_rsp_t               rsp,
  // bus monitor
  input  wire logic                         monitor_en,
  // address and control pins
  output logic [aebm_pkg::ADDR_W-1:0]       addr_out,
  output logic                              xfer_size_hi,
  output logic                              xfer_size_lo,
  output logic [2:0]                        address_space_code,
  output logic                              rw_read,
  output logic                              address_valid_strobe_n,
  output logic                              data_valid_strobe_n,
  // data pins
  input  wire logic [aebm_pkg::DATA_W-1:0]  data_in,
  output logic [aebm_pkg::DATA_W-1:0]       data_out,
  output logic                              data_oe,
  // termination pins
  input  wire logic                         port_ack_hi_n,
  input  wire logic                         port_ack_lo_n,
  input  wire logic                         bus_fault_in_n,
  input  wire logic                         halt_in_n,
  input  wire logic                         internal_vector_request_n
);

  localparam int AW    = aebm_pkg::ADDR_W;
  localparam int OW    = aebm_pkg::OP_W;
  localparam int MON_W = $clog2(MON_CYCLES) + 1;

  ////////////////////////////////////////////////////////////////////////////

  aebm_pkg::aebm_state_t st_reg;
  aebm_pkg::aebm_state_t st_next;
  aebm_pkg::aebm_req_t   req_reg;

  logic [AW-1:0]    addr_reg;
  logic [2:0]       rem_reg;
  logic [2:0]       rem_next;
  logic [2:0]       step;
  logic [OW-1:0]    op_reg;
  logic [OW-1:0]    acc_reg;
  logic [OW-1:0]    acc_next;
  logic [OW-1:0]    op_init;
  logic [1:0]       size_reg;
  logic [2:0]       space_reg;
  logic             rw_reg;
  logic [15:0]      dout_reg;
  logic             doe_reg;
  logic             last_reg;
  logic [MON_W-1:0] mon_cnt;
  logic             mon_fault;
  logic [1:0]       ack_pair;
  logic             ack_done;
  logic             fault;
  logic             internal_vector_request;
  logic             term;
  logic             wide;
  logic [15:0]      wr_lanes;
  logic [15:0]      rd_bits;
  logic             accept;
  logic             as_on;

  ////////////////////////////////////////////////////////////////////////////
  // termination decode
  assign ack_pair = {port_ack_hi_n, port_ack_lo_n};
  // reserved code waits like 11
  assign ack_done = (ack_pair == aebm_pkg::ACK_PORT8) ||
                    (ack_pair == aebm_pkg::ACK_PORT16);
  assign fault    = !bus_fault_in_n || mon_fault;
  // vector request counts only in interrupt acknowledge cycles
  assign internal_vector_request     = req_reg.iack && !internal_vector_request_n;
  assign term     = ack_done || fault || internal_vector_request;
  assign accept   = req_valid && (st_reg == aebm_pkg::ST_IDLE);
  assign step     = wide ? aebm_pkg::REM_TWO : aebm_pkg::REM_ONE;
  assign rem_next = rem_reg - step;

  aebm_lane u_lane (
    .op       (op_reg),
    .rem      (rem_reg),
    .addr0    (addr_reg[0]),
    .port16   (ack_pair == aebm_pkg::ACK_PORT16),
    .rd_bus   (data_in),
    .wide     (wide),
    .wr_lanes (wr_lanes),
    .rd_bits  (rd_bits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: one state per half bus clock
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      aebm_pkg::ST_IDLE:
        if (req_valid)
          st_next = aebm_pkg::ST_ADDR;
      aebm_pkg::ST_ADDR:
        st_next = aebm_pkg::ST_ASRT;
      aebm_pkg::ST_ASRT:
        if (rw_reg)
          st_next = aebm_pkg::ST_WAIT;
        else
          st_next = aebm_pkg::ST_WDAT;
      aebm_pkg::ST_WDAT:
        st_next = aebm_pkg::ST_WAIT;
      aebm_pkg::ST_WAIT:
        if (term)
          st_next = aebm_pkg::ST_END;
      aebm_pkg::ST_END:
        if (last_reg)
          st_next = aebm_pkg::ST_IDLE;
        else
          st_next = aebm_pkg::ST_ADDR;
      default:
        st_next = aebm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= aebm_pkg::ST_IDLE;
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand bookkeeping
  always_comb
  begin
    unique case (req.size)
      aebm_pkg::SIZE_LONG:  op_init = req.wdata;
      aebm_pkg::SIZE_3BYTE: op_init = {req.wdata[23:0], 8'h00};
      aebm_pkg::SIZE_WORD:  op_init = {req.wdata[15:0], 16'h0000};
      aebm_pkg::SIZE_BYTE:  op_init = {req.wdata[7:0], 24'h000000};
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_reg  <= '0;
      addr_reg <= '0;
      rem_reg  <= aebm_pkg::REM_ZERO;
      op_reg   <= '0;
      last_reg <= 1'b0;
    end
    else if (accept)
    begin
      req_reg  <= req;
      addr_reg <= req.addr;
      op_reg   <= op_init;
      last_reg <= 1'b0;
      if (req.size == aebm_pkg::SIZE_LONG)
        rem_reg <= aebm_pkg::REM_LONG;
      else
        rem_reg <= {1'b0, req.size};
    end
    else if (st_reg == aebm_pkg::ST_WAIT && term)
    begin
      // next cycle points at the next most significant byte
      addr_reg <= addr_reg + AW'(step);
      rem_reg  <= rem_next;
      op_reg   <= wide ? {op_reg[15:0], 16'h0000} : {op_reg[23:0], 8'h00};
      last_reg <= (rem_next == aebm_pkg::REM_ZERO) || fault || internal_vector_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins that hold for the whole cycle, loaded at its start
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      size_reg  <= aebm_pkg::SIZE_BYTE;
      space_reg <= aebm_pkg::SPACE_USER_DATA;
      addr_out  <= '0;
    end
    else if (st_next == aebm_pkg::ST_ADDR)
    begin
      // bytes left 4,1,2,3 map onto 00,01,10,11
      size_reg  <= accept ? req.size : rem_reg[1:0];
      space_reg <= accept ? req.space : req_reg.space;
      addr_out  <= accept ? req.addr : addr_reg;
    end
  end

  // direction resets high, holds between cycles and moves only when a cycle starts
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rw_reg <= 1'b1;
    else if (accept)
      rw_reg <= !req.write;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write data lanes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_reg <= '0;
      doe_reg  <= 1'b0;
    end
    else if (st_next == aebm_pkg::ST_WDAT)
    begin
      dout_reg <= wr_lanes;
      doe_reg  <= 1'b1;
    end
    else if (st_reg == aebm_pkg::ST_END)
      doe_reg  <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read assembly and result
  always_comb
  begin
    if (wide)
      acc_next = {acc_reg[15:0], rd_bits};
    else
      acc_next = {acc_reg[23:0], rd_bits[7:0]};
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_reg <= '0;
      rsp     <= '0;
    end
    else if (accept)
    begin
      acc_reg <= '0;
      rsp     <= '0;
    end
    else if (st_reg == aebm_pkg::ST_WAIT && term)
    begin
      // data latched on the edge that closes the cycle
      if (rw_reg && ack_done && !fault && !internal_vector_request)
        acc_reg <= acc_next;
      rsp.fault    <= fault;
      rsp.bus_fault_in_exc <= fault && !halt_in_n;
      rsp.autovec  <= internal_vector_request && !fault;
    end
    else if (st_reg == aebm_pkg::ST_END)
      rsp.rdata <= acc_reg;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rsp_valid <= 1'b0;
    else
      rsp_valid <= (st_reg == aebm_pkg::ST_END) && last_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus monitor: faults a cycle that waits too long
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mon_cnt <= '0;
    else if (st_reg == aebm_pkg::ST_WAIT && !term)
      mon_cnt <= mon_cnt + MON_W'(1);
    else
      mon_cnt <= '0;
  end

  assign mon_fault = monitor_en && (mon_cnt == MON_W'(MON_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign req_ready    = (st_reg == aebm_pkg::ST_IDLE);
  assign xfer_size_hi = size_reg[1];
  assign xfer_size_lo = size_reg[0];
  assign address_space_code = space_reg;
  assign rw_read      = rw_reg;
  assign data_out     = dout_reg;
  assign data_oe      = doe_reg;
  assign as_on = (st_reg == aebm_pkg::ST_ASRT) ||
                 (st_reg == aebm_pkg::ST_WDAT) ||
                 (st_reg == aebm_pkg::ST_WAIT);
  assign address_valid_strobe_n = !as_on;
  assign data_valid_strobe_n =
    !((st_reg == aebm_pkg::ST_WAIT) ||
      (st_reg == aebm_pkg::ST_ASRT && rw_reg));

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr_start;
    $fell(address_valid_strobe_n) && !rw_read;
  endsequence
  sequence s_rd_start;
    $fell(address_valid_strobe_n) && rw_read;
  endsequence
  a_size_held: assert property (
    as_on |=> (!as_on ||
      $stable({xfer_size_hi, xfer_size_lo})))
    else $error("size pins moved under address strobe");
  a_space_held: assert property (
    as_on |=> (!as_on || $stable(address_space_code)))
    else $error("space code moved under address strobe");
  a_addr_held: assert property (
    as_on |=> (!as_on || $stable(addr_out)))
    else $error("address moved under address strobe");
  a_dir_at_start: assert property (
    $changed(rw_read) |-> st_reg == aebm_pkg::ST_ADDR &&
      address_valid_strobe_n)
    else $error("direction changed outside cycle start");
  a_strobe_half: assert property (
    st_reg == aebm_pkg::ST_ADDR |-> address_valid_strobe_n
      ##1 !address_valid_strobe_n)
    else $error("address strobe not half a clock after start");
  a_rd_ds_same: assert property (
    s_rd_start |-> !data_valid_strobe_n)
    else $error("read data strobe late");
  a_wr_ds_full: assert property (
    s_wr_start |-> data_valid_strobe_n [*2]
      ##1 !data_valid_strobe_n)
    else $error("write data strobe not one clock after strobe");
  a_wr_data_half: assert property (
    s_wr_start |-> !data_oe ##1 (data_oe && !address_valid_strobe_n))
    else $error("write data not driven half a clock after strobe");
  a_wr_lanes_on: assert property (
    s_wr_start ##2 !data_valid_strobe_n |-> data_oe throughout
      (!data_valid_strobe_n [*1] ##1 1'b1))
    else $error("write lanes released while data strobe on");
  a_close_cycle: assert property (
    st_reg == aebm_pkg::ST_WAIT && term |=>
      address_valid_strobe_n && data_valid_strobe_n ##1
      address_valid_strobe_n)
    else $error("strobes not closed after termination");
  a_wait_extend: assert property (
    st_reg == aebm_pkg::ST_WAIT && !term |=>
      !address_valid_strobe_n && !data_valid_strobe_n)
    else $error("cycle ended without termination");
  a_internal_vector_request_ignored: assert property (
    st_reg == aebm_pkg::ST_WAIT && !req_reg.iack && !ack_done &&
      !fault |=> st_reg == aebm_pkg::ST_WAIT)
    else $error("vector request ended a plain cycle");
  a_bus_fault_in_exc: assert property (
    st_reg == aebm_pkg::ST_WAIT && fault && !halt_in_n |=>
      rsp.bus_fault_in_exc ##1 (rsp_valid && rsp.fault))
    else $error("fault with halt gave no exception");
  a_long_size: assert property (
    st_reg == aebm_pkg::ST_ADDR && rem_reg == aebm_pkg::REM_LONG |->
      {xfer_size_hi, xfer_size_lo} == aebm_pkg::SIZE_LONG)
    else $error("long word size code wrong");

endmodule : aebm_master

// >>> hdl/aebm_pkg.sv
package aebm_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int OP_W   = 32;
  localparam int BYTE_W = 8;

  // size pin codes
  localparam logic [1:0] SIZE_BYTE  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] SIZE_3BYTE = 2'h3;
  localparam logic [1:0] SIZE_LONG  = 2'h0;

  // address space codes
  localparam logic [2:0] SPACE_USER_DATA = 3'h1;
  localparam logic [2:0] SPACE_USER_PROG = 3'h2;
  localparam logic [2:0] SPACE_SUPV_DATA = 3'h5;
  localparam logic [2:0] SPACE_SUPV_PROG = 3'h6;
  localparam logic [2:0] SPACE_CONTROL   = 3'h7;

  // acknowledge pair levels {hi, lo}
  localparam logic [1:0] ACK_WAIT   = 2'h3;
  localparam logic [1:0] ACK_PORT8  = 2'h2;
  localparam logic [1:0] ACK_PORT16 = 2'h1;
  localparam logic [1:0] ACK_RSVD   = 2'h0;

  // bytes left in the operand
  localparam logic [2:0] REM_ZERO = 3'h0;
  localparam logic [2:0] REM_ONE  = 3'h1;
  localparam logic [2:0] REM_TWO  = 3'h2;
  localparam logic [2:0] REM_LONG = 3'h4;

  localparam int MON_CYCLES_DEF = 64;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ASRT = 6'h04,
    ST_WDAT = 6'h08,
    ST_WAIT = 6'h10,
    ST_END  = 6'h20
  } aebm_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [1:0]        size;
    logic              write;
    logic [2:0]        space;
    logic              iack;
    logic [OP_W-1:0]   wdata;
  } aebm_req_t;

  typedef struct packed {
    logic [OP_W-1:0] rdata;
    logic            fault;
    logic            bus_fault_in_exc;
    logic            autovec;
  } aebm_rsp_t;

endpackage : aebm_pkg

// >>> test/aebm_slave_model.sv
`timescale 1ns/1ns
module aebm_slave_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // scenario controls: 0 ack, 1 fault, 2 fault+halt, 3 vector,
  // 4 ack with vector held, 5 silent, 6 reserved ack
  input  wire logic        port16,
  input  wire logic [3:0]  waits,
  input  wire logic [2:0]  mode,
  // bus pins
  input  wire logic [23:0] addr,
  input  wire logic [1:0]  size,
  input  wire logic        rw_read,
  input  wire logic        ds_n,
  input  wire logic [15:0] wdata,
  output logic [15:0]      rdata,
  output logic             ack_hi_n,
  output logic             ack_lo_n,
  output logic             fault_n,
  output logic             halt_n,
  output logic             vec_n
);
  logic [7:0] mem [256];
  logic [7:0] a;
  logic       two;
  logic       busy;
  int         cnt;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i * 37 + 5);
    {ack_hi_n, ack_lo_n, fault_n, halt_n, vec_n} = 5'h1f;
    rdata = 16'h5aa5;
    busy = 1'b0;
    cnt = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    #1;
    if (!rst_n || ds_n !== 1'b0)
    begin
      // released lines: acks pulled up, data shows no stale value
      if (busy)
        rdata = ~rdata;
      {ack_hi_n, ack_lo_n, fault_n, halt_n} = 4'hf;
      vec_n = (mode != 3'h4);
      busy = 1'b0;
      cnt = 0;
    end
    else if (!busy && cnt < int'(waits))
      cnt++;
    else if (!busy)
    begin
      busy = 1'b1;
      a = addr[7:0];
      two = port16 && !a[0] && size != aebm_pkg::SIZE_BYTE;
      if (rw_read && port16)
        rdata = a[0] ? {~mem[a], mem[a]} : {mem[a], mem[8'(a + 1)]};
      else if (rw_read)
        rdata = {mem[a], ~mem[a]};
      else if (port16 && a[0])
        mem[a] = wdata[7:0];
      else
      begin
        mem[a] = wdata[15:8];
        if (two)
          mem[8'(a + 1)] = wdata[7:0];
      end
      case (mode)
        3'h1: fault_n = 1'b0;
        3'h2: {fault_n, halt_n} = 2'h0;
        3'h3: vec_n = 1'b0;
        3'h5: cnt = 0;
        3'h6: {ack_hi_n, ack_lo_n} = 2'h0;
        default: {ack_hi_n, ack_lo_n} = port16 ? 2'h1 : 2'h2;
      endcase
    end
  end
endmodule : aebm_slave_model

// >>> test/tb_top.sv
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_top;
  logic                core_clk;
  logic                rst_n;
  logic                req_valid;
  aebm_pkg::aebm_req_t req;
  logic                req_ready;
  logic                rsp_valid;
  aebm_pkg::aebm_rsp_t rsp;
  logic                monitor_en;
  logic [23:0]         addr_out;
  logic                xfer_size_hi;
  logic                xfer_size_lo;
  logic [2:0]          address_space_code;
  logic                rw_read;
  logic                as_n;
  logic                ds_n;
  logic [15:0]         data_out;
  logic                data_oe;
  logic [15:0]         slave_rdata;
  logic [15:0]         data_bus;
  logic                ack_hi_n;
  logic                ack_lo_n;
  logic                fault_n;
  logic                halt_n;
  logic                vec_n;
  logic                p16;
  logic [3:0]          waits;
  logic [2:0]          mode;
  logic                as_prev;
  logic [66:0]         note;
  logic [66:0]         exp_q [$];
  logic [29:0]         bus_q [$];
  logic [2:0]          spaces [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  logic [23:0]         a;
  logic [31:0]         d;
  int                  seed;
  int                  error_cnt = 0;
  int                  n_tests = 0;

  assign data_bus = data_oe ? data_out : slave_rdata;

  aebm_master #(.MON_CYCLES(8)) aebm_master_i (
    .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .monitor_en(monitor_en), .addr_out(addr_out),
    .xfer_size_hi(xfer_size_hi), .xfer_size_lo(xfer_size_lo),
    .address_space_code(address_space_code), .rw_read(rw_read),
    .address_valid_strobe_n(as_n), .data_valid_strobe_n(ds_n),
    .data_in(data_bus), .data_out(data_out), .data_oe(data_oe),
    .port_ack_hi_n(ack_hi_n), .port_ack_lo_n(ack_lo_n),
    .bus_fault_in_n(fault_n), .halt_in_n(halt_n),
    .internal_vector_request_n(vec_n));

  aebm_slave_model aebm_slave_model_i (
    .core_clk(core_clk), .rst_n(rst_n), .port16(p16), .waits(waits),
    .mode(mode), .addr(addr_out), .size({xfer_size_hi, xfer_size_lo}),
    .rw_read(rw_read), .ds_n(ds_n), .wdata(data_bus), .rdata(slave_rdata),
    .ack_hi_n(ack_hi_n), .ack_lo_n(ack_lo_n), .fault_n(fault_n),
    .halt_n(halt_n), .vec_n(vec_n));

  ////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  function automatic logic [31:0] mask_of(input logic [1:0] s);
    case (s)
      2'h1: return 32'h000000ff;
      2'h2: return 32'h0000ffff;
      2'h3: return 32'h00ffffff;
      default: return 32'hffffffff;
    endcase
  endfunction : mask_of

  // one record per bus cycle, taken mid-cycle after the strobe falls
  always @(negedge core_clk)
  begin
    if (as_n === 1'b0 && as_prev === 1'b1)
      bus_q.push_back({addr_out, xfer_size_hi, xfer_size_lo,
                       address_space_code, rw_read});
    as_prev = as_n;
    if (rsp_valid === 1'b1)
    begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      `CHK(rsp.rdata & note[34:3], note[66:35])
      `CHK({rsp.fault, rsp.bus_fault_in_exc, rsp.autovec}, note[2:0])
    end
  end

  task automatic check_bus(input logic [23:0] ca, input logic [1:0] s,
                           input logic w, input logic [2:0] sp);
    int          rem;
    int          step;
    logic [23:0] ak;
    logic [29:0] got;
    rem = (s == 2'h0) ? 4 : int'(s);
    ak = ca;
    while (rem > 0)
    begin
      got = (bus_q.size() > 0) ? bus_q.pop_front() : 30'h0;
      `CHK(got, {ak, 2'(rem), sp, ~w})
      step = (p16 && !ak[0] && rem >= 2) ? 2 : 1;
      ak = ak + 24'(step);
      rem = rem - step;
    end
    `CHK(bus_q.size(), 0)
  endtask : check_bus

  task automatic run(input logic [23:0] ra, input logic [1:0] s,
                     input logic w, input logic [2:0] sp, input logic ia,
                     input logic [31:0] rd, input logic [2:0] fl);
    int          k;
    logic [31:0] m;
    m = (w || fl != 3'h0) ? 32'h0 : mask_of(s);
    exp_q.push_back({rd & m, m, fl});
    req = '{addr: ra, size: s, write: w, space: sp, iack: ia, wdata: rd};
    req_valid = 1'b1;
    k = 0;
    while (req_ready !== 1'b1 && k < 100)
    begin
      @(posedge core_clk);
      #2;
      k++;
    end
    `CHK(req_ready, 1'b1)
    @(posedge core_clk);
    #2;
    req_valid = 1'b0;
    `CHK(req_ready, 1'b0)
    k = 0;
    while (rsp_valid !== 1'b1 && k < 300)
    begin
      @(posedge core_clk);
      #2;
      k++;
    end
    if (k >= 300)
    begin
      error_cnt++;
      conclude();
    end
    if (fl == 3'h0)
      check_bus(ra, s, w, sp);
    else
      bus_q.delete();
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial
  begin
    #2000000;
    error_cnt++;
    conclude();
  end

  initial
  begin
    seed = 32'h6843;
    {rst_n, req_valid, monitor_en, mode, waits} = '0;
    req = '0;
    p16 = 1'b1;
    as_prev = 1'b1;
    repeat (8) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    @(posedge core_clk);
    #2;
    // every size on both port widths, random data and wait states
    for (int i = 0; i < 8; i++)
    begin
      p16 = (i < 4);
      d = $random(seed);
      a = {16'($random(seed)), 8'($random(seed)) & 8'h7c};
      a[0] = (i == 1);
      waits = 4'($random(seed)) & 4'h7;
      run(a, 2'(i), 1'b1, spaces[i % 5], 1'b0, d, 3'h0);
      run(a, 2'(i), 1'b0, spaces[i % 5], 1'b0, d, 3'h0);
    end
    // back to back writes, then long wait states on read back
    run(24'h40, 2'h2, 1'b1, 3'h1, 1'b0, 32'h1234, 3'h0);
    run(24'h43, 2'h1, 1'b1, 3'h1, 1'b0, 32'h9a, 3'h0);
    p16 = 1'b1;
    waits = 4'hc;
    run(24'h40, 2'h2, 1'b0, 3'h1, 1'b0, 32'h1234, 3'h0);
    run(24'h43, 2'h1, 1'b0, 3'h1, 1'b0, 32'h9a, 3'h0);
    // abnormal terminations, plus a plain read acknowledged with the vector request held
    waits = 4'h1;
    mode = 3'h1;
    run(24'h50, 2'h2, 1'b0, 3'h5, 1'b0, 32'h0, 3'h4);
    mode = 3'h2;
    run(24'h50, 2'h0, 1'b0, 3'h5, 1'b0, 32'h0, 3'h6);
    mode = 3'h3;
    run(24'h58, 2'h1, 1'b0, 3'h7, 1'b1, 32'h0, 3'h1);
    mode = 3'h4;
    run(24'h40, 2'h2, 1'b0, 3'h1, 1'b0, 32'h1234, 3'h0);
    mode = 3'h5;
    monitor_en = 1'b1;
    run(24'h60, 2'h2, 1'b0, 3'h5, 1'b0, 32'h0, 3'h4);
    mode = 3'h6;
    run(24'h62, 2'h2, 1'b0, 3'h1, 1'b0, 32'h0, 3'h4);
    monitor_en = 1'b0;
    mode = 3'h0;
    repeat (4) @(posedge core_clk);
    `CHK(exp_q.size(), 0)
    conclude();
  end
endmodule : tb_top
